// ### hw/char_glyph_and_attribute_unit.sv
//Contract
//- With glyph_source_select 0, codes 00H-7FH come from the internal glyph ROM and 80H-FFH from external glyph RAM.
//- With glyph_source_select 1, all codes come from external glyph RAM and the internal ROM is never used.
//- Each external glyph is eight consecutive row bytes, so the area is 0400H or 0800H bytes.
//- The programmed 5-bit offset forms the top five bits of the external glyph address.
//- A glyph is loaded by pointing the memory pointer at its first row and doing eight write-with-increment stores.
//- Attributes use the attribute home register (attr_home) as attribute area, and graphics are not shown meanwhile.
//- Attribute low nibble codes normal, reverse, inhibit and their blinking forms; bits 7-4 are ignored.
//- The attribute byte at position n of the attribute area applies to text character n.
//- Normal and reverse attributes act on text characters only.
`timescale 1ns/100ps
module char_glyph_and_attribute_unit #(
  parameter int blink_half = glyph_pkg::blink_half_cycles
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_code,
  input  wire logic [2:0]  req_row,
  input  wire logic [15:0] req_index,
  output logic             pix_valid,
  output logic [7:0]       pix_row,
  output logic             graphics_enable,
  output logic             mem_req,
  output logic             mem_we,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata
);
  import glyph_pkg::*;

  if (blink_half < 1) begin : g_chk
    $error("blink_half must be at least one cycle");
  end

  typedef enum logic [2:0] {st_idle, st_write, st_attr, st_glyph, st_out} state_e;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic        glyph_source_select;
  logic        attr_enable;
  logic [4:0]  offset;
  logic [15:0] attr_home;
  logic [15:0] mem_ptr;
  logic [7:0]  wr_byte;
  logic        wr_pend;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  strb_q;

  wire do_write = aw_held && w_held && !bvalid;
  wire hit_ctrl = aw_q == ctrl_addr;
  wire hit_off  = aw_q == offset_addr;
  wire hit_attr = aw_q == attr_home_addr;
  wire hit_ptr  = aw_q == mem_ptr_addr;
  wire hit_wdat = aw_q == mem_wdata_addr;
  wire hit_stat = aw_q == status_addr;
  wire wr_ok    = hit_ctrl || hit_off || hit_attr || hit_ptr || hit_wdat || hit_stat;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  state_e state;
  state_e next_state;
  logic   ptr_step;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= 8'h00;
      w_q     <= 32'h0000_0000;
      strb_q  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= resp_okay;
    end else begin
      awready <= !aw_held && !(awvalid && awready) && !wr_pend;
      wready  <= !w_held && !(wvalid && wready);
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_q    <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_q    <= wdata;
        strb_q <= wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? resp_okay : resp_slverr;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {attr_enable, glyph_source_select} <= ctrl_reset;
      offset    <= offset_reset;
      attr_home <= attr_home_reset;
      mem_ptr   <= mem_ptr_reset;
      wr_byte   <= 8'h00;
      wr_pend   <= 1'b0;
    end else begin
      if (do_write && hit_ctrl && strb_q[0]) begin
        glyph_source_select <= w_q[ctrl_src_bit];
        attr_enable         <= w_q[ctrl_attr_bit];
      end
      if (do_write && hit_off && strb_q[0]) begin
        offset <= w_q[offset_bits-1:0];
      end
      if (do_write && hit_attr) begin
        attr_home <= merge16(attr_home, w_q, strb_q);
      end
      if (do_write && hit_ptr) begin
        mem_ptr <= merge16(mem_ptr, w_q, strb_q);
      end else if (ptr_step) begin
        mem_ptr <= mem_ptr + 16'h0001;
      end
      if (do_write && hit_wdat && strb_q[0]) begin
        wr_byte <= w_q[7:0];
        wr_pend <= 1'b1;
      end else if (ptr_step) begin
        wr_pend <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel
  logic last_rom;
  wire [31:0] status_word = {29'h0, wr_pend, last_rom, state != st_idle};
  wire [31:0] rd_word =
    (araddr == ctrl_addr)      ? {30'h0, attr_enable, glyph_source_select} :
    (araddr == offset_addr)    ? {27'h0, offset} :
    (araddr == attr_home_addr) ? {16'h0, attr_home} :
    (araddr == mem_ptr_addr)   ? {16'h0, mem_ptr} :
    (araddr == mem_wdata_addr) ? {24'h0, wr_byte} :
    (araddr == status_addr)    ? status_word : 32'h0000_0000;
  wire rd_ok = (araddr == ctrl_addr) || (araddr == offset_addr) || (araddr == attr_home_addr) ||
               (araddr == mem_ptr_addr) || (araddr == mem_wdata_addr) || (araddr == status_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= resp_okay;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= rd_ok ? resp_okay : resp_slverr;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Glyph fetch
  glyph_rom_if rom_bus ();
  internal_glyph_rom u_rom (.port_rom(rom_bus.rom));

  logic [7:0] cur_code;
  logic [2:0] cur_row;
  logic [3:0] attr_nib;
  logic [31:0] blink_cnt;
  logic        blink_off;

  // The fetch that leaves idle must see the request itself, not the previous code
  wire [7:0]  sel_code   = (state == st_idle) ? req_code : cur_code;
  wire [2:0]  sel_row    = (state == st_idle) ? req_row : cur_row;
  wire use_ext   = glyph_source_select || cur_code[7];
  wire fetch_ext = glyph_source_select || sel_code[7];
  wire [15:0] glyph_addr = {offset, sel_code, sel_row};
  wire [15:0] attr_addr  = attr_home + req_index;
  assign rom_bus.code = cur_code[6:0];
  assign rom_bus.row  = cur_row;

  wire [7:0] glyph_raw = use_ext ? mem_rdata : rom_bus.data;
  wire is_rev = (attr_nib == attr_reverse) || (attr_nib == attr_blink_rev);
  wire is_inh = (attr_nib == attr_inhibit) || (attr_nib == attr_blink_inh);
  wire is_blk = (attr_nib == attr_blink) || (attr_nib == attr_blink_rev) || (attr_nib == attr_blink_inh);
  wire [7:0] shaded = is_inh ? 8'h00 : (is_blk && blink_off) ? 8'h00 : is_rev ? ~glyph_raw : glyph_raw;
  wire mem_done = mem_req && mem_ack;
  assign ptr_step = (state == st_write) && mem_done;

  always_comb begin
    next_state = state;
    case (state)
      st_idle:  begin
        if (wr_pend) begin
          next_state = st_write;
        end else if (req_valid && req_ready) begin
          next_state = attr_enable ? st_attr : st_glyph;
        end
      end
      st_write: begin
        if (mem_done) begin
          next_state = st_idle;
        end
      end
      st_attr:  begin
        if (mem_done) begin
          next_state = st_glyph;
        end
      end
      st_glyph: begin
        if (!use_ext || mem_done) begin
          next_state = st_out;
        end
      end
      default:  next_state = st_idle;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state           <= st_idle;
      req_ready       <= 1'b0;
      cur_code        <= 8'h00;
      cur_row         <= 3'h0;
      attr_nib        <= attr_normal;
      mem_req         <= 1'b0;
      mem_we          <= 1'b0;
      mem_addr        <= 16'h0000;
      mem_wdata       <= 8'h00;
      pix_valid       <= 1'b0;
      pix_row         <= 8'h00;
      last_rom        <= 1'b0;
      graphics_enable <= 1'b1;
    end else begin
      state           <= next_state;
      req_ready       <= (next_state == st_idle) && !wr_pend && !(do_write && hit_wdat);
      graphics_enable <= !attr_enable;
      pix_valid       <= 1'b0;
      mem_req         <= 1'b0;
      mem_we          <= 1'b0;
      if (state == st_idle && next_state == st_write) begin
        mem_req   <= 1'b1;
        mem_we    <= 1'b1;
        mem_addr  <= mem_ptr;
        mem_wdata <= wr_byte;
      end
      if (state == st_idle && req_valid && req_ready && !wr_pend) begin
        cur_code <= req_code;
        cur_row  <= req_row;
        attr_nib <= attr_normal;
        if (attr_enable) begin
          mem_req  <= 1'b1;
          mem_addr <= attr_addr;
        end
      end
      if ((state == st_write || state == st_attr || state == st_glyph) && mem_req && !mem_ack) begin
        mem_req <= 1'b1;
        mem_we  <= mem_we;
      end
      if (state == st_attr && mem_done) begin
        attr_nib <= mem_rdata[3:0];
      end
      if (next_state == st_glyph && state != st_glyph && fetch_ext) begin
        mem_req  <= 1'b1;
        mem_addr <= glyph_addr;
      end
      if (state == st_glyph && next_state == st_out) begin
        pix_valid <= 1'b1;
        pix_row   <= shaded;
        last_rom  <= !use_ext;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_cnt <= 32'h0000_0000;
      blink_off <= 1'b0;
    end else if (blink_cnt == 32'(blink_half - 1)) begin
      blink_cnt <= 32'h0000_0000;
      blink_off <= !blink_off;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

endmodule // char_glyph_and_attribute_unit

// ### hw/glyph_pkg.sv
package glyph_pkg;

  // Register byte addresses
  localparam logic [7:0] ctrl_addr      = 8'h00;
  localparam logic [7:0] offset_addr    = 8'h04;
  localparam logic [7:0] attr_home_addr = 8'h08;
  localparam logic [7:0] mem_ptr_addr   = 8'h0c;
  localparam logic [7:0] mem_wdata_addr = 8'h10;
  localparam logic [7:0] status_addr    = 8'h14;

  // Control fields
  localparam int ctrl_src_bit  = 0;
  localparam int ctrl_attr_bit = 1;

  // Status fields
  localparam int stat_busy_bit = 0;
  localparam int stat_rom_bit  = 1;
  localparam int stat_wrp_bit  = 2;

  // Reset values
  localparam logic [1:0]  ctrl_reset      = 2'h0;
  localparam logic [4:0]  offset_reset    = 5'h00;
  localparam logic [15:0] attr_home_reset = 16'h0000;
  localparam logic [15:0] mem_ptr_reset   = 16'h0000;

  // Glyph geometry
  localparam int glyph_rows   = 8;
  localparam int row_bits     = 3;
  localparam int offset_bits  = 5;
  localparam int code_bits    = 8;
  localparam int rom_codes    = 128;

  // Attribute nibble codes
  localparam logic [3:0] attr_normal      = 4'h0;
  localparam logic [3:0] attr_reverse     = 4'h5;
  localparam logic [3:0] attr_inhibit     = 4'h3;
  localparam logic [3:0] attr_blink       = 4'h8;
  localparam logic [3:0] attr_blink_rev   = 4'hd;
  localparam logic [3:0] attr_blink_inh   = 4'hb;

  // Blink half period
  localparam int blink_half_cycles = 25000000;

  // AXI responses
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

endpackage

// ### hw/glyph_rom_if.sv
`timescale 1ns/100ps
interface glyph_rom_if;
  logic [6:0] code;
  logic [2:0] row;
  logic [7:0] data;
  modport user (output code, output row, input data);
  modport rom  (input code, input row, output data);
endinterface

// ### hw/internal_glyph_rom.sv
`timescale 1ns/100ps
module internal_glyph_rom (
  glyph_rom_if.rom port_rom
);
  import glyph_pkg::*;

  // Fixed 128 x 8 table built as a constant; the pattern stands in for the font
  function automatic logic [7:0] pattern(input logic [6:0] c, input logic [2:0] r);
    logic [7:0] v;
    v = {1'b0, c} ^ {r, r, r[2:1]};
    if (r == 3'h7) begin
      v = 8'h00;
    end
    return v;
  endfunction

  logic [7:0] table_q [rom_codes*glyph_rows];

  for (genvar i = 0; i < rom_codes*glyph_rows; i++) begin : g_rom
    assign table_q[i] = pattern(7'(i / glyph_rows), 3'(i % glyph_rows));
  end

  wire [9:0] index = {port_rom.code, port_rom.row};
  assign port_rom.data = table_q[index];

endmodule // internal_glyph_rom

// ### tb/glyph_unit_assertions.sv
`timescale 1ns/100ps
module glyph_unit_assertions
  import glyph_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        pix_valid,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_ack,
  input wire logic [15:0] mem_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data not one cycle after address");
  read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before rready");
  read_block_a: assert property (rvalid |-> !arready)
    else $error("read address taken while data pending");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before ack");
  pix_pulse_a: assert property (pix_valid |=> !pix_valid)
    else $error("pixel valid longer than one cycle");
  scan_busy_a: assert property (req_valid && req_ready |=> !req_ready)
    else $error("scan accepted while busy");
  scan_answer_a: assert property (req_valid && req_ready |-> ##[2:60] pix_valid)
    else $error("scan row not answered");
  //////////////////////////////
  cover property (pix_valid);
  cover property (mem_req && mem_we && mem_ack);
  cover property (bvalid && bresp == resp_slverr);
endmodule // glyph_unit_assertions

bind char_glyph_and_attribute_unit glyph_unit_assertions u_chk (.*);

// ### tb/display_memory_model.sv
`timescale 1ns/100ps
module display_memory_model (
  input wire logic        aclk,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  mem_wdata,
  input wire logic [1:0]  lag,
  output logic            mem_ack,
  output logic [7:0]      mem_rdata,
  output logic [15:0]     last_rd
);
  logic [7:0] bytes [0:65535];
  int         wait_n;
  initial begin
    for (int i = 0; i < 65536; i++) bytes[i] = i[7:0] ^ 8'h5a;
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    last_rd = 16'h0000;
    wait_n = 0;
  end
  // Read data is only valid in the ack cycle; otherwise it keeps toggling
  always @(posedge aclk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      if (wait_n < lag) wait_n <= wait_n + 1;
      else begin
        wait_n <= 0;
        mem_ack <= 1'b1;
        if (mem_we) bytes[mem_addr] <= mem_wdata;
        else begin
          mem_rdata <= bytes[mem_addr];
          last_rd <= mem_addr;
        end
      end
    end
  end
endmodule // display_memory_model

// ### tb/char_glyph_and_attribute_unit_bench.sv
`timescale 1ns/100ps
module char_glyph_and_attribute_unit_bench;
  import glyph_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic req_valid, req_ready, pix_valid, graphics_enable, mem_req, mem_we, mem_ack, done;
  logic [7:0]  awaddr, araddr, req_code, pix_row, mem_wdata, mem_rdata, code, got, b;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, lag, rs;
  logic [2:0]  req_row;
  logic [4:0]  off;
  logic [15:0] req_index, mem_addr, last_rd, ga, base, prev, idx;
  logic [3:0]  nib [6] = '{attr_normal, attr_reverse, attr_inhibit, attr_blink, attr_blink_rev, attr_blink_inh};
  int          n_mismatch, total_checks, cycles, ram [int];

  char_glyph_and_attribute_unit #(.blink_half(4)) u_dut (.*);
  display_memory_model u_mem (.*);

  always #10 aclk = ~aclk;
  //////////////////////////////
  task automatic finish_test;
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test;
    end
  end
  task automatic check_reg(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Blinking cells may also show blank during the off phase
  task automatic check_pix(input logic [7:0] g, input logic [7:0] e, input logic bl);
    total_checks++;
    if (!(g === e || (bl && g === 8'h00))) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    return ram.exists(int'(a)) ? ram[int'(a)][7:0] : a[7:0] ^ 8'h5a;
  endfunction
  function automatic logic [7:0] apply(input logic [7:0] r, input logic [3:0] n);
    case (n)
      attr_reverse, attr_blink_rev: return ~r;
      attr_inhibit, attr_blink_inh: return 8'h00;
      default: return r;
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp; bready <= 1'b0; done = 1'b1;
      end
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rd = rdata; rs = rresp; rready <= 1'b0; done = 1'b1;
      end
    end
  endtask
  task automatic scan(input logic [7:0] c, input logic [2:0] r, input logic [15:0] i);
    req_valid <= 1'b1; req_code <= c; req_row <= r; req_index <= i; lag <= 2'($urandom_range(3));
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (req_valid && req_ready) req_valid <= 1'b0;
      if (pix_valid) begin
        got = pix_row; done = 1'b1;
      end
    end
  endtask
  //////////////////////////////
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; req_valid = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; req_code = 0; req_row = 0; req_index = 0; lag = 0;
    n_mismatch = 0; total_checks = 0; cycles = 0;
    void'($urandom(35125));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdr(ctrl_addr); check_reg(rd, 32'(ctrl_reset));
    rdr(offset_addr); check_reg(rd, 32'(offset_reset));
    rdr(attr_home_addr); check_reg(rd, 32'(attr_home_reset));
    rdr(mem_ptr_addr); check_reg(rd, 32'(mem_ptr_reset));
    rdr(8'h3c);
    check_reg(rd, 32'h0000_0000);
    check_reg(32'(rs), 32'(resp_slverr));
    wr(8'h3c, 32'h1); check_reg(32'(rs), 32'(resp_slverr));
    off = 5'($urandom); code = 8'h80 | 8'($urandom);
    ga = {off, code, 3'h0};
    wr(offset_addr, 32'(off));
    wr(mem_ptr_addr, 32'(ga));
    for (int r = 0; r < glyph_rows; r++) begin
      b = 8'($urandom); ram[int'(ga) + r] = b;
      wr(mem_wdata_addr, 32'(b));
    end
    // The last byte may still be on its way to memory; wait until it has landed
    do begin
      rdr(status_addr);
    end while (rd[stat_wrp_bit]);
    rdr(mem_ptr_addr); check_reg(rd, 32'(ga + 16'h0008));
    for (int r = 0; r < glyph_rows; r++) begin
      scan(code, 3'(r), 16'h0);
      check_pix(got, exp_byte(ga + 16'(r)), 1'b0);
      check_reg(32'(last_rd), 32'(ga + 16'(r)));
    end
    prev = last_rd;
    scan(code & 8'h7f, 3'h3, 16'h0);
    rdr(status_addr); check_reg({31'h0, rd[stat_rom_bit]}, 32'h1);
    check_reg(32'(last_rd), 32'(prev));
    wr(ctrl_addr, 32'h1);
    scan(code & 8'h7f, 3'h5, 16'h0);
    check_pix(got, exp_byte({off, code & 8'h7f, 3'h5}), 1'b0);
    rdr(status_addr); check_reg({31'h0, rd[stat_rom_bit]}, 32'h0);
    base = 16'($urandom) & 16'h7f00;
    wr(attr_home_addr, 32'(base));
    wr(ctrl_addr, 32'h3);
    @(posedge aclk); check_reg({31'h0, graphics_enable}, 32'h0);
    for (int k = 0; k < 6; k++) begin
      idx = 16'($urandom_range(200));
      wr(mem_ptr_addr, 32'(base + idx));
      b = {4'($urandom), nib[k]};
      ram[int'(base + idx)] = b;
      wr(mem_wdata_addr, 32'(b));
      scan(code, 3'(k), idx);
      check_pix(got, apply(exp_byte({off, code, 3'(k)}), nib[k]), nib[k][3]);
    end
    wr(ctrl_addr, 32'h0);
    @(posedge aclk); check_reg({31'h0, graphics_enable}, 32'h1);
    finish_test;
  end
endmodule // char_glyph_and_attribute_unit_bench
